// ===== pt_encoder_model.sv
// Two-phase encoder standing at the external clock pins.
// Assumes single-cycle step requests from the bench.
`timescale 1ns/1ps
module pt_encoder_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic step_up,
  input wire logic step_down,
  output logic phase_a,
  output logic phase_b
);
  logic [1:0] pos_reg;
  logic [1:0] pos_next;

  always_comb begin
    pos_next = pos_reg;
    if (step_up) begin
      pos_next = pos_reg + 2'h1;
    end else if (step_down) begin
      pos_next = pos_reg - 2'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pos_reg <= 2'h0;
    end else begin
      pos_reg <= pos_next;
    end
  end

  // Gray order: one phase moves per step, A ahead of B going up
  assign phase_a = pos_reg[0] ^ pos_reg[1];
  assign phase_b = pos_reg[1];
endmodule : pt_encoder_model

// ===== pt_pkg.sv
// Constants shared by the pulse timer unit and its helper modules.
// Assumes every user reads field codes through these names only.
package pt_pkg;

  localparam int NUM_CH = 6;
  localparam int CNT_W = 16;
  localparam int NUM_GR = 4;

  // Channel operating modes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PWM1 = 2'h1;
  localparam logic [1:0] MODE_PWM2 = 2'h2;
  localparam logic [1:0] MODE_PHASE = 2'h3;

  // Counter clear sources
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_A = 2'h1;
  localparam logic [1:0] CLR_B = 2'h2;
  localparam logic [1:0] CLR_SYNC = 2'h3;

  // Prescaler: codes 0..6 divide by 2**code, code 7 is the cascade clock on channels 1 and 4, divide by 128 elsewhere
  localparam int PSC_W = 7;
  localparam logic [2:0] PSC_CASCADE = 3'h7;

  // Pin action field: bit 3 capture, bit 2 initial level, bits 1:0 action
  localparam int ACT_CAP_BIT = 3;
  localparam int ACT_INIT_BIT = 2;
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;
  localparam logic [1:0] OUT_NONE = 2'h0;
  localparam logic [1:0] OUT_LOW = 2'h1;
  localparam logic [1:0] OUT_HIGH = 2'h2;
  localparam logic [1:0] OUT_TOGGLE = 2'h3;

  // Register select on the write port
  localparam logic [2:0] SEL_CNT = 3'h0;
  localparam logic [2:0] SEL_A = 3'h1;
  localparam logic [2:0] SEL_D = 3'h4;

  // Channel capability masks, bit n is channel n
  localparam logic [5:0] BUF_CH_MASK = 6'h09;
  localparam logic [5:0] PHASE_CH_MASK = 6'h36;
  localparam logic [5:0] CASC_CH_MASK = 6'h12;

  // Values after reset and the counter maximum
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] GR_RESET = 16'hFFFF;
  localparam logic DIR_RESET = 1'b1;

endpackage : pt_pkg

// ===== pt_prescale.sv
// Shared free-running prescaler producing one-cycle count enables.
// Assumes all channels sample the enables in the same clock domain.
`timescale 1ns/1ps
module pt_prescale
  import pt_pkg::*;
#(
  parameter int WIDTH = PSC_W
) (
  input wire logic ref_clk,
  input wire logic resetn,
  output logic [WIDTH:0] tick
);

  logic [WIDTH-1:0] div_reg;
  logic [WIDTH-1:0] div_next;

  always_comb begin
    div_next = div_reg + 1'b1;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  assign tick[0] = 1'b1;
  for (genvar k = 1; k <= WIDTH; k++) begin : g_tick
    assign tick[k] = &div_reg[k-1:0];
  end

endmodule : pt_prescale

// ===== pt_quad.sv
// Two-phase encoder decoder, every edge of one phase alone counts once.
// Assumes phase inputs are already synchronous to ref_clk.
`timescale 1ns/1ps
module pt_quad (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic phase_a,
  input wire logic phase_b,
  output logic count_up,
  output logic count_down
);

  logic a_reg;
  logic b_reg;
  logic one_edge;

  // Both phases moving at once carries no direction; it is dropped
  always_comb begin
    one_edge = (phase_a ^ a_reg) ^ (phase_b ^ b_reg);
    count_up = one_edge && (phase_a ^ b_reg);
    count_down = one_edge && (phase_b ^ a_reg);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      a_reg <= 1'b0;
      b_reg <= 1'b0;
    end else begin
      a_reg <= phase_a;
      b_reg <= phase_b;
    end
  end

endmodule : pt_quad

// ===== pt_unit.sv
// Six-channel 16-bit pulse timer unit: buffer, cascade, PWM, phase count.
// Assumes all pins are synchronous to ref_clk and software drives the
// configuration ports directly; there is no register bus.
// Functional notes
// - Only channels 0 and 3 buffer; C buffers A, D buffers B.
// - Buffered compare match copies buffer into general register with pin.
// - Buffered capture loads counter and shifts old value into buffer.
// - Channels 1 over 2 and 4 over 5 form 32-bit counters.
// - Cascaded upper counts up on lower overflow, down on underflow.
// - Lower counter underflows only while in two-phase counting mode.
// - Upper channel in two-phase mode ignores cascade clock selection.
// - Same-edge captures store upper half on channel 1, lower on 2.
// - PWM compare matches drive 0, 1 or toggle; 0 to 100 duty.
// - Clear source sets PWM period; each channel chooses PWM alone.
// - PWM mode 1 pairs A with B, C with D on pins A, C.
// - PWM mode 1 starts from the initial level of A or C.
// - Equal governing registers leave the PWM pin unchanged on match.
// - PWM mode 1 gives up to eight output phases.
// - PWM mode 2: cycle match clear returns pins to initial level.
// - PWM mode 2 with sync gives up to fifteen phases.
// - PWM mode 2 cycle register pin gives no output.
// - Two-phase mode only on 1,2,4,5; forces encoder clock, up/down.
// - Clear, pin control, capture and compare still work in two-phase.
// - Up past maximum sets overflow; down below zero sets underflow.
// - Status shows a readable count direction flag.
// - Channels 1,5 use ext pins A,B; channels 2,4 use C,D.
// - Mode 1 counts up when A leads B, down when B leads.
// - Overflow wraps from all ones to zero and keeps counting.
`timescale 1ns/1ps
module pt_unit
  import pt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [5:0] start,
  input wire logic [5:0] sync_enable,
  input wire logic [5:0] buffer_enable,
  input wire logic [11:0] mode_select,
  input wire logic [17:0] prescaler_select,
  input wire logic [11:0] clear_source_select,
  input wire logic [23:0] pin_a_action,
  input wire logic [23:0] pin_b_action,
  input wire logic [23:0] pin_c_action,
  input wire logic [23:0] pin_d_action,
  input wire logic wr_en,
  input wire logic [2:0] wr_chan,
  input wire logic [2:0] wr_sel,
  input wire logic [15:0] wr_data,
  input wire logic [5:0] overflow_clear,
  input wire logic [5:0] underflow_clear,
  input wire logic [23:0] match_clear,
  input wire logic ext_clock_pin_a,
  input wire logic ext_clock_pin_b,
  input wire logic ext_clock_pin_c,
  input wire logic ext_clock_pin_d,
  input wire logic [23:0] io_pin_in,
  output logic [23:0] io_pin_out,
  output logic [23:0] io_pin_oe,
  output logic [95:0] channel_counter,
  output logic [95:0] general_reg_a,
  output logic [95:0] general_reg_b,
  output logic [95:0] general_reg_c,
  output logic [95:0] general_reg_d,
  output logic [5:0] overflow_flag,
  output logic [5:0] underflow_flag,
  output logic [5:0] direction_flag,
  output logic [23:0] match_flag
);

  logic [PSC_W:0] tick;
  logic [1:0] q_up;
  logic [1:0] q_dn;
  logic [5:0] ovf_ev;
  logic [5:0] unf_ev;
  logic [5:0] sync_req;

  function automatic logic pt_level(input logic cur, input logic [3:0] a);
    logic lvl;
    unique case (a[1:0])
      OUT_NONE: lvl = cur;
      OUT_LOW: lvl = 1'b0;
      OUT_HIGH: lvl = 1'b1;
      OUT_TOGGLE: lvl = ~cur;
    endcase
    return lvl;
  endfunction : pt_level

  pt_prescale #(
    .WIDTH(PSC_W)
  ) u_prescale (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .tick(tick)
  );

  pt_quad u_quad_ab (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .phase_a(ext_clock_pin_a),
    .phase_b(ext_clock_pin_b),
    .count_up(q_up[0]),
    .count_down(q_dn[0])
  );

  pt_quad u_quad_cd (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .phase_a(ext_clock_pin_c),
    .phase_b(ext_clock_pin_d),
    .count_up(q_up[1]),
    .count_down(q_dn[1])
  );

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam int LO = (i == 1) ? 2 : 5;
    localparam int QS = (i == 2 || i == 4) ? 1 : 0;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [15:0] gr_reg [NUM_GR];
    logic [15:0] gr_next [NUM_GR];
    logic [3:0] out_reg;
    logic [3:0] out_next;
    logic [3:0] oe_reg;
    logic [3:0] oe_next;
    logic [3:0] prev_reg;
    logic [3:0] mflag_reg;
    logic [3:0] mflag_next;
    logic ovf_reg;
    logic ovf_next;
    logic unf_reg;
    logic unf_next;
    logic dir_reg;
    logic dir_next;
    logic [3:0] act [NUM_GR];
    logic [3:0] pin_ok;
    logic [3:0] rise;
    logic [3:0] fall;
    logic [3:0] cmp_hit;
    logic [3:0] cap_hit;
    logic [3:0] ev;
    logic [1:0] mode;
    logic [1:0] clr;
    logic [2:0] psc;
    logic phase;
    logic casc;
    logic run;
    logic up;
    logic dn;
    logic clr_own;
    logic clear;
    logic bufm;
    logic cnt_wr;
    logic has_cyc;
    logic [1:0] cyc;

    // Count enables and per-register events
    always_comb begin
      mode = mode_select[2*i +: 2];
      clr = clear_source_select[2*i +: 2];
      psc = prescaler_select[3*i +: 3];
      act[0] = pin_a_action[4*i +: 4];
      act[1] = pin_b_action[4*i +: 4];
      act[2] = pin_c_action[4*i +: 4];
      act[3] = pin_d_action[4*i +: 4];
      phase = (mode == MODE_PHASE) && PHASE_CH_MASK[i];
      casc = CASC_CH_MASK[i] && (psc == PSC_CASCADE) && !phase;
      run = start[i];
      if (phase) begin
        up = run && q_up[QS];
        dn = run && q_dn[QS];
      end else if (casc) begin
        up = run && ovf_ev[LO];
        dn = run && unf_ev[LO];
      end else begin
        up = run && tick[psc];
        dn = 1'b0;
      end
      for (int r = 0; r < NUM_GR; r++) begin
        pin_ok[r] = (r < 2) || BUF_CH_MASK[i];
        rise[r] = io_pin_in[4*i+r] && !prev_reg[r];
        fall[r] = !io_pin_in[4*i+r] && prev_reg[r];
        cmp_hit[r] = pin_ok[r] && !act[r][ACT_CAP_BIT] && (up || dn)
                     && (cnt_reg == gr_reg[r]);
        cap_hit[r] = pin_ok[r] && act[r][ACT_CAP_BIT]
                     && ((act[r][EDGE_RISE_BIT] && rise[r])
                     || (act[r][EDGE_FALL_BIT] && fall[r]));
      end
      ev = cmp_hit | cap_hit;
      clr_own = ((clr == CLR_A) && ev[0]) || ((clr == CLR_B) && ev[1]);
    end

    // Cascade events ignore the lower clear to keep the pair loop-free
    assign ovf_ev[i] = up && (cnt_reg == CNT_MAX);
    assign unf_ev[i] = dn && (cnt_reg == CNT_ZERO);
    assign sync_req[i] = sync_enable[i] && clr_own;

    // Next state of counter, general registers, flags and pins
    always_comb begin
      clear = clr_own
              || ((clr == CLR_SYNC) && sync_enable[i] && (|sync_req));
      cnt_wr = wr_en && (wr_sel == SEL_CNT) && ((wr_chan == i)
               || (sync_enable[i] && (wr_chan < NUM_CH)
               && sync_enable[wr_chan]));
      cnt_next = cnt_reg;
      if (cnt_wr) begin
        cnt_next = wr_data;
      end else if (clear) begin
        cnt_next = CNT_ZERO;
      end else if (up) begin
        cnt_next = cnt_reg + 16'h0001;
      end else if (dn) begin
        cnt_next = cnt_reg - 16'h0001;
      end
      bufm = buffer_enable[i] && BUF_CH_MASK[i];
      gr_next = gr_reg;
      for (int r = 0; r < 2; r++) begin
        if (cap_hit[r]) begin
          gr_next[r] = cnt_reg;
          if (bufm) begin
            gr_next[r+2] = gr_reg[r];
          end
        end else if (cmp_hit[r] && bufm) begin
          gr_next[r] = gr_reg[r+2];
        end
      end
      for (int r = 2; r < NUM_GR; r++) begin
        if (!bufm && cap_hit[r]) begin
          gr_next[r] = cnt_reg;
        end
      end
      if (wr_en && (wr_chan == i) && (wr_sel >= SEL_A)
          && (wr_sel <= SEL_D)) begin
        gr_next[2'(wr_sel - SEL_A)] = wr_data;
      end
      // Hardware set wins over a clear in the same cycle
      mflag_next = (mflag_reg & ~match_clear[4*i +: 4]) | ev;
      ovf_next = (ovf_reg && !overflow_clear[i]) || ovf_ev[i];
      unf_next = (unf_reg && !underflow_clear[i]) || unf_ev[i];
      dir_next = dir_reg;
      if (up) begin
        dir_next = 1'b1;
      end else if (dn) begin
        dir_next = 1'b0;
      end
      has_cyc = (clr == CLR_A) || (clr == CLR_B);
      cyc = (clr == CLR_B) ? 2'h1 : 2'h0;
      out_next = out_reg;
      oe_next = '0;
      unique case (mode)
        MODE_PWM1: begin
          for (int r = 0; r < NUM_GR; r += 2) begin
            oe_next[r] = pin_ok[r];
            if (!run) begin
              out_next[r] = act[r][ACT_INIT_BIT];
            end else if (gr_reg[r] != gr_reg[r+1]) begin
              if (ev[r]) begin
                out_next[r] = pt_level(out_reg[r], act[r]);
              end
              if (ev[r+1]) begin
                out_next[r] = pt_level(out_next[r], act[r+1]);
              end
            end
          end
        end
        MODE_PWM2: begin
          for (int r = 0; r < NUM_GR; r++) begin
            // Sync-cleared channels take their cycle from another channel
            oe_next[r] = pin_ok[r] && !(has_cyc && (r == cyc));
            if (!run || clear) begin
              out_next[r] = act[r][ACT_INIT_BIT];
            end else if (cmp_hit[r]
                && !(has_cyc && (gr_reg[r] == gr_reg[cyc]))) begin
              out_next[r] = pt_level(out_reg[r], act[r]);
            end
          end
        end
        MODE_NORMAL, MODE_PHASE: begin
          for (int r = 0; r < NUM_GR; r++) begin
            oe_next[r] = pin_ok[r] && !act[r][ACT_CAP_BIT]
                         && (act[r][1:0] != OUT_NONE);
            if (!run) begin
              out_next[r] = act[r][ACT_INIT_BIT];
            end else if (cmp_hit[r]) begin
              out_next[r] = pt_level(out_reg[r], act[r]);
            end
          end
        end
      endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        cnt_reg <= CNT_ZERO;
        for (int r = 0; r < NUM_GR; r++) begin
          gr_reg[r] <= GR_RESET;
        end
        out_reg <= '0;
        oe_reg <= '0;
        prev_reg <= '0;
        mflag_reg <= '0;
        ovf_reg <= 1'b0;
        unf_reg <= 1'b0;
        dir_reg <= DIR_RESET;
      end else begin
        cnt_reg <= cnt_next;
        gr_reg <= gr_next;
        out_reg <= out_next;
        oe_reg <= oe_next;
        prev_reg <= io_pin_in[4*i +: 4];
        mflag_reg <= mflag_next;
        ovf_reg <= ovf_next;
        unf_reg <= unf_next;
        dir_reg <= dir_next;
      end
    end

    assign channel_counter[16*i +: 16] = cnt_reg;
    assign general_reg_a[16*i +: 16] = gr_reg[0];
    assign general_reg_b[16*i +: 16] = gr_reg[1];
    assign general_reg_c[16*i +: 16] = gr_reg[2];
    assign general_reg_d[16*i +: 16] = gr_reg[3];
    assign io_pin_out[4*i +: 4] = out_reg;
    assign io_pin_oe[4*i +: 4] = oe_reg;
    assign match_flag[4*i +: 4] = mflag_reg;
    assign overflow_flag[i] = ovf_reg;
    assign underflow_flag[i] = unf_reg;
    assign direction_flag[i] = dir_reg;
  end

endmodule : pt_unit

// ===== pt_unit_checker.sv
// Concurrent checks on the pulse timer unit ports.
// Assumes a bind into pt_unit; watches channels 0 to 4 only.
`timescale 1ns/1ps
module pt_unit_checker
  import pt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [5:0] start,
  input wire logic [5:0] buffer_enable,
  input wire logic [11:0] mode_select,
  input wire logic [17:0] prescaler_select,
  input wire logic [11:0] clear_source_select,
  input wire logic [23:0] pin_a_action,
  input wire logic wr_en,
  input wire logic ext_clock_pin_a,
  input wire logic ext_clock_pin_b,
  input wire logic [23:0] io_pin_oe,
  input wire logic [95:0] channel_counter,
  input wire logic [95:0] general_reg_a,
  input wire logic [95:0] general_reg_c,
  input wire logic [5:0] overflow_flag,
  input wire logic [5:0] underflow_flag,
  input wire logic [23:0] match_flag
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // Free wrap of channel 2, no write or clear able to fake it
  sequence s_lower_wrap;
    channel_counter[47:32] == CNT_MAX && !wr_en
    && clear_source_select[5:4] == CLR_NONE
    ##1 channel_counter[47:32] == CNT_ZERO;
  endsequence
  sequence s_casc_on;
    prescaler_select[5:3] == PSC_CASCADE && start[1] && !wr_en
    && mode_select[3:2] != MODE_PHASE
    && clear_source_select[3:2] == CLR_NONE;
  endsequence
  sequence s_a_leads;
    mode_select[3:2] == MODE_PHASE && start[1] && !ext_clock_pin_b
    && $stable(ext_clock_pin_b) && $rose(ext_clock_pin_a)
    && clear_source_select[3:2] == CLR_NONE;
  endsequence

  a_ovf_on_wrap: assert property (
    s_lower_wrap |-> ##[0:1] overflow_flag[2])
    else $error("overflow flag missing after wrap");
  a_casc_up_count: assert property (s_casc_on ##0 s_lower_wrap
    |-> channel_counter[31:16] == $past(channel_counter[31:16]) + 16'h0001)
    else $error("upper half did not follow lower wrap");
  // The count lands on the edge that first sees the new phase level
  a_phase_up: assert property (s_a_leads ##0 !wr_en
    |-> ##1 channel_counter[31:16] == $past(channel_counter[31:16]) + 16'h0001)
    else $error("encoder step did not count up");
  a_no_underflow: assert property (
    (mode_select[5:4] != MODE_PHASE) [*2] |-> !$rose(underflow_flag[2]))
    else $error("underflow outside phase mode");
  a_pwm1_pin_dir: assert property (
    (mode_select[1:0] == MODE_PWM1 && start[0]) [*3]
    |-> io_pin_oe[0] && !io_pin_oe[1])
    else $error("pwm mode 1 pin enables wrong");
  a_pwm2_cycle_pin: assert property (
    (mode_select[9:8] == MODE_PWM2 && clear_source_select[9:8] == CLR_B
    && start[4]) [*3] |-> !io_pin_oe[17] && io_pin_oe[16])
    else $error("pwm mode 2 cycle pin drives");
  a_buf_compare: assert property ($rose(match_flag[0])
    && $past(buffer_enable[0]) && !$past(pin_a_action[3]) && !$past(wr_en)
    |-> general_reg_a[15:0] == $past(general_reg_c[15:0]))
    else $error("buffer not copied on compare");
  a_buf_capture: assert property ($rose(match_flag[12])
    && $past(buffer_enable[3]) && $past(pin_a_action[15]) && !$past(wr_en)
    |-> general_reg_c[63:48] == $past(general_reg_a[63:48])
    && general_reg_a[63:48] == $past(channel_counter[63:48]))
    else $error("capture buffer shift wrong");
endmodule : pt_unit_checker

bind pt_unit pt_unit_checker u_checker (.*);

// ===== pt_unit_tb.sv
// Self-checking bench for the pulse timer unit.
// Assumes the checker is bound in and the encoder model drives the pins.
`timescale 1ns/1ps
module pt_unit_tb
  import pt_pkg::*;
;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic wr_en = 1'b0;
  logic step_up = 1'b0;
  logic step_down = 1'b0;
  logic [5:0] start = 6'h00;
  logic [5:0] buffer_enable = 6'h00;
  logic [5:0] sync_enable = 6'h00;
  logic [5:0] overflow_clear = 6'h00;
  logic [5:0] underflow_clear = 6'h00;
  logic [23:0] match_clear = 24'h000000;
  logic [11:0] mode_select = 12'h000;
  logic [11:0] clear_source_select = 12'h000;
  logic [17:0] prescaler_select = 18'h00000;
  logic [23:0] pin_a_action = 24'h000000;
  logic [23:0] pin_b_action = 24'h000000;
  logic [23:0] pin_c_action = 24'h000000;
  logic [23:0] pin_d_action = 24'h000000;
  logic [23:0] io_pin_in = 24'h000000;
  logic [2:0] wr_chan = 3'h0;
  logic [2:0] wr_sel = 3'h0;
  logic [15:0] wr_data = 16'h0000;
  logic ext_clock_pin_a, ext_clock_pin_b;
  logic [23:0] io_pin_out, io_pin_oe, match_flag;
  logic [95:0] channel_counter, general_reg_a, general_reg_b;
  logic [95:0] general_reg_c, general_reg_d;
  logic [5:0] overflow_flag, underflow_flag, direction_flag;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;

  // Channels 2 and 4 share the encoder so their phase inputs move too
  pt_unit dut (
    .*,
    .ext_clock_pin_c(ext_clock_pin_a),
    .ext_clock_pin_d(ext_clock_pin_b)
  );
  pt_encoder_model encoder (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .step_up(step_up),
    .step_down(step_down),
    .phase_a(ext_clock_pin_a),
    .phase_b(ext_clock_pin_b)
  );

  task automatic check16(input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : check16

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [2:0] ch, input logic [2:0] sel,
                    input logic [15:0] d);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    wr_chan <= ch;
    wr_sel <= sel;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic step(input logic up, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      step_up <= up;
      step_down <= !up;
      @(posedge ref_clk);
      step_up <= 1'b0;
      step_down <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
    tick(3);
  endtask : step

  task automatic finish_test;
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic t_pwm1_buffer;
    wr(3'h0, SEL_A, 16'h0004);
    wr(3'h0, 3'h2, 16'h0002);
    wr(3'h0, 3'h3, 16'h0006);
    wr(3'h0, SEL_D, 16'h0005);
    @(posedge ref_clk);
    mode_select[1:0] <= MODE_PWM1;
    clear_source_select[1:0] <= CLR_A;
    buffer_enable[0] <= 1'b1;
    pin_a_action[3:0] <= 4'h6;
    pin_b_action[3:0] <= 4'h1;
    tick(3);
    check16(16'h0001, {15'h0000, io_pin_out[0]});
    check16(16'h0001, {15'h0000, io_pin_oe[0]});
    check16(16'h0000, {15'h0000, io_pin_oe[1]});
    @(posedge ref_clk);
    start[0] <= 1'b1;
    tick(11);
    check16(16'h0006, general_reg_a[15:0]);
    check16(16'h0001, {15'h0000, match_flag[0]});
    check16(16'h0005, general_reg_b[15:0]);
    check16(16'h0005, general_reg_d[15:0]);
    check16(16'h0000, {15'h0000, io_pin_out[0]});
    check16(16'h0006, channel_counter[15:0]);
  endtask : t_pwm1_buffer

  // Counter held still so the captured values are known in advance
  task automatic t_capture_buffer;
    @(posedge ref_clk);
    buffer_enable[3] <= 1'b1;
    pin_a_action[15:12] <= 4'h9;
    wr(3'h3, SEL_CNT, 16'h0100);
    tick(2);
    @(posedge ref_clk);
    io_pin_in[12] <= 1'b1;
    tick(4);
    check16(16'h0100, general_reg_a[63:48]);
    check16(GR_RESET, general_reg_c[63:48]);
    @(posedge ref_clk);
    io_pin_in[12] <= 1'b0;
    wr(3'h3, SEL_CNT, 16'h0200);
    tick(2);
    @(posedge ref_clk);
    io_pin_in[12] <= 1'b1;
    tick(4);
    check16(16'h0200, general_reg_a[63:48]);
    check16(16'h0100, general_reg_c[63:48]);
  endtask : t_capture_buffer

  task automatic t_cascade;
    wr(3'h2, SEL_CNT, 16'hFFFE);
    wr(3'h1, SEL_CNT, 16'h0005);
    @(posedge ref_clk);
    prescaler_select[5:3] <= PSC_CASCADE;
    start[2:1] <= 2'h3;
    tick(5);
    check16(16'h0006, channel_counter[31:16]);
    check16(16'h0001, {15'h0000, overflow_flag[2]});
    @(posedge ref_clk);
    start[2:1] <= 2'h0;
  endtask : t_cascade

  // Cascade clock stays selected on channel 1 and must be ignored
  task automatic t_phase;
    wr(3'h1, SEL_CNT, 16'h0000);
    @(posedge ref_clk);
    mode_select[3:2] <= MODE_PHASE;
    start[1] <= 1'b1;
    step(1'b1, 4);
    check16(16'h0004, channel_counter[31:16]);
    check16(16'h0001, {15'h0000, direction_flag[1]});
    step(1'b0, 6);
    check16(16'hFFFE, channel_counter[31:16]);
    check16(16'h0001, {15'h0000, underflow_flag[1]});
    check16(16'h0000, {15'h0000, direction_flag[1]});
    @(posedge ref_clk);
    underflow_clear[1] <= 1'b1;
    overflow_clear[2] <= 1'b1;
    @(posedge ref_clk);
    underflow_clear[1] <= 1'b0;
    overflow_clear[2] <= 1'b0;
    tick(1);
    check16(16'h0000, {15'h0000, underflow_flag[1]});
    check16(16'h0000, {15'h0000, overflow_flag[2]});
  endtask : t_phase

  // Channel 5 follows channel 4's period through the sync clear
  task automatic t_pwm2;
    wr(3'h4, SEL_A, 16'h0003);
    wr(3'h4, 3'h2, 16'h0008);
    @(posedge ref_clk);
    mode_select[9:8] <= MODE_PWM2;
    clear_source_select[11:8] <= {CLR_SYNC, CLR_B};
    pin_a_action[19:16] <= 4'h3;
    sync_enable[5:4] <= 2'h3;
    start[5:4] <= 2'h3;
    tick(6);
    check16(16'h0001, {15'h0000, io_pin_out[16]});
    tick(6);
    check16(16'h0000, {15'h0000, io_pin_out[16]});
    check16(16'h0003, channel_counter[95:80]);
    check16(16'h0000, {15'h0000, io_pin_oe[17]});
    check16(16'h0001, {15'h0000, io_pin_oe[16]});
  endtask : t_pwm2

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      finish_test();
    end
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    tick(2);
    check16(GR_RESET, general_reg_a[15:0]);
    t_pwm1_buffer();
    t_capture_buffer();
    t_cascade();
    t_phase();
    t_pwm2();
    finish_test();
  end
endmodule : pt_unit_tb
